// file: src/vds_sequencer.sv
// file: enable qualification, soft-start ramp and on-the-fly dac stepping
// assumes: enable, comparator and code inputs already synchronous to aclk
module vds_sequencer #(
  parameter int SLOT_CLKS = 42
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic por_ok,
  input wire logic en_cmp_high,
  input wire logic logic_level_enable,
  input wire logic [5:0] voltage_identification_code,
  input wire logic dac_reached_vout,
  input wire logic vout_in_window,
  input wire logic ov_detect,
  output logic [7:0] dac_units,
  output logic [3:0] rs_offset_units,
  output logic pwm_drive_en,
  output logic ov_trip_shutdown,
  output logic power_good_output
);
  import vds_pkg::*;

  vds_state_t state_ff, nxt_state;
  logic slot_pulse, cycle_pulse;
  logic [5:0] vid_smp_ff;
  logic [7:0] dac_ff, tgt;
  logic [3:0] ofs_ff;
  logic [10:0] ss_cnt_ff;
  logic [1:0] nl_cnt_ff, pend_slots_ff;
  logic sw_en_ff, ov_latch_ff, ovsd_ff, pwm_ff, pg_ff, reach_ff;
  logic pend_ff, pend_up_ff, chase_ff;
  logic noload, nl_shut, en_ok, dir_up, far, cancel, run_step, ramp_tick;
  logic [1:0] ramp_units;
  logic wr_en, wr_err, rd_err;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;

  vds_slot_timer #(.SLOT_CLKS(SLOT_CLKS)) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .slot_pulse(slot_pulse),
    .cycle_pulse(cycle_pulse)
  );

  vds_axil_slave #(.ADDR_W(8)) u_bus (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_err(wr_err), .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(rd_err)
  );

  // code sampled at each of the six slots of a cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vid_smp_ff <= VID_NOLOAD_A;
    end else if (slot_pulse) begin
      vid_smp_ff <= voltage_identification_code;
    end
  end

  assign tgt = vds_vid_units(vid_smp_ff);
  assign noload = vds_is_noload(vid_smp_ff);
  assign nl_shut = noload && (nl_cnt_ff == NOLOAD_DELAY_CYCLES);
  assign en_ok = por_ok && en_cmp_high && logic_level_enable && sw_en_ff && !ov_latch_ff;

  // switching cycles spent on a no-load code
  always_ff @(posedge aclk) begin
    if (!aresetn || !noload) begin
      nl_cnt_ff <= 2'h0;
    end else if (cycle_pulse && nl_cnt_ff != NOLOAD_DELAY_CYCLES) begin
      nl_cnt_ff <= nl_cnt_ff + 2'h1;
    end
  end

  // overvoltage latch, cleared only by dropping en_cmp_high, logic_level_enable or por_ok
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_ok || !en_cmp_high || !logic_level_enable) begin
      ov_latch_ff <= 1'b0;
    end else if (ov_detect && state_ff != ST_SHUT) begin
      ov_latch_ff <= 1'b1;
    end
  end

  // sequencing state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_SHUT: if (en_ok && !noload) nxt_state = ST_WAIT;
      ST_WAIT: if (cycle_pulse && ss_cnt_ff == 11'(SS_WAIT_CYCLES - 1)) nxt_state = ST_RAMP;
      ST_RAMP: if (!noload && dac_ff >= tgt) nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_SHUT;
    endcase
    if (!en_ok || nl_shut) begin
      nxt_state = ST_SHUT;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_SHUT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // switching cycles since the state was entered, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn || nxt_state != state_ff) begin
      ss_cnt_ff <= 11'h0;
    end else if (cycle_pulse && ss_cnt_ff != 11'h7ff) begin
      ss_cnt_ff <= ss_cnt_ff + 11'h1;
    end
  end

  // ramp cadence: 25mV each 32 cycles early, 12.5mV each 16 later
  always_comb begin
    if (int'(ss_cnt_ff) < SS_FAST_CYCLES) begin
      ramp_tick = ((int'(ss_cnt_ff) + 1) % FAST_STEP_CYCLES) == 0;
      ramp_units = 2'(FAST_STEP_UNITS);
    end else begin
      ramp_tick = ((int'(ss_cnt_ff) + 1) % CYC_PER_UNIT) == 0;
      ramp_units = 2'h1;
    end
  end

  // on-the-fly stepping decisions
  assign dir_up = tgt > dac_ff;
  assign far = dir_up ? (tgt - dac_ff > 8'h1) : (dac_ff - tgt > 8'h1);
  assign cancel = pend_ff && (dir_up != pend_up_ff || dac_ff == tgt);
  assign run_step = slot_pulse && state_ff == ST_RUN && !noload && !cancel &&
    (far || (chase_ff && dac_ff != tgt) || (pend_ff && pend_slots_ff == 2'h1));

  // half-cycle wait before a single step
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != ST_RUN || noload) begin
      pend_ff <= 1'b0;
      pend_slots_ff <= 2'h0;
      pend_up_ff <= 1'b0;
      chase_ff <= 1'b0;
    end else if (slot_pulse) begin
      chase_ff <= far;
      if (pend_ff) begin
        pend_slots_ff <= pend_slots_ff - 2'h1;
        if (cancel || pend_slots_ff == 2'h1) begin
          pend_ff <= 1'b0;
        end
      end else if (dac_ff != tgt && !far && !chase_ff) begin
        pend_ff <= 1'b1;
        pend_slots_ff <= 2'(HALF_CYCLE_SLOTS);
        pend_up_ff <= dir_up;
      end
    end
  end

  // reference dac level in 12.5mV units
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff == ST_SHUT || state_ff == ST_WAIT) begin
      dac_ff <= 8'h0;
    end else if (state_ff == ST_RAMP && cycle_pulse && ramp_tick && dac_ff < tgt) begin
      dac_ff <= (tgt - dac_ff > {6'h0, ramp_units}) ? dac_ff + {6'h0, ramp_units} : tgt;
    end else if (run_step) begin
      dac_ff <= dir_up ? dac_ff + 8'h1 : dac_ff - 8'h1;
    end
  end

  // remote-sense offset: 100mV at start, one unit off each 80 cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_ff <= 4'h0;
    end else if (state_ff == ST_SHUT && nxt_state == ST_WAIT) begin
      ofs_ff <= OFS_START_UNITS;
    end else if (state_ff == ST_RAMP && cycle_pulse && ofs_ff != 4'h0 &&
                 ((int'(ss_cnt_ff) + 1) % OFS_CYC_PER_UNIT) == 0) begin
      ofs_ff <= ofs_ff - 4'h1;
    end
  end

  // pwm, power good and trip level, following the next state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reach_ff <= 1'b0;
      pwm_ff <= 1'b0;
      pg_ff <= 1'b0;
      ovsd_ff <= 1'b0;
    end else begin
      reach_ff <= (nxt_state == ST_RAMP) && (reach_ff || dac_reached_vout);
      pwm_ff <= (nxt_state == ST_RUN) ||
        (nxt_state == ST_RAMP && (reach_ff || dac_reached_vout));
      pg_ff <= (nxt_state == ST_RUN) && vout_in_window;
      if (state_ff == ST_SHUT && nxt_state == ST_WAIT) begin
        ovsd_ff <= 1'b0;
      end else if (nl_shut || ov_latch_ff) begin
        ovsd_ff <= 1'b1;
      end
    end
  end

  // software control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_en_ff <= CTRL_EN_RESET;
    end else if (wr_en && wr_addr == REG_CTRL && wr_strb[0]) begin
      sw_en_ff <= wr_data[CTRL_EN_BIT];
    end
  end

  assign wr_err = (wr_addr != REG_CTRL) && (wr_addr != REG_STATUS) && (wr_addr != REG_DAC);

  // register read decode
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (rd_addr)
      REG_CTRL: rd_data[CTRL_EN_BIT] = sw_en_ff;
      REG_STATUS: begin
        rd_data[3:0] = state_ff;
        rd_data[STAT_PG_BIT] = pg_ff;
        rd_data[STAT_PWM_BIT] = pwm_ff;
        rd_data[STAT_OVL_BIT] = ov_latch_ff;
        rd_data[STAT_OVSD_BIT] = ovsd_ff;
        rd_data[STAT_NOLOAD_BIT] = noload;
      end
      REG_DAC: begin
        rd_data[7:0] = dac_ff;
        rd_data[DAC_TGT_LSB +: 8] = tgt;
        rd_data[DAC_OFS_LSB +: 4] = ofs_ff;
      end
      default: rd_err = 1'b1;
    endcase
  end

  assign dac_units = dac_ff;
  assign rs_offset_units = ofs_ff;
  assign pwm_drive_en = pwm_ff;
  assign ov_trip_shutdown = ovsd_ff;
  assign power_good_output = pg_ff;

  property p_shut_hiz;
    @(posedge aclk) disable iff (!aresetn) (state_ff == ST_SHUT) |-> !pwm_ff;
  endproperty
  a_shut_hiz: assert property (p_shut_hiz)
    else $error("pwm driven during shutdown");

  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_SHUT && en_ok && !noload) |=> (state_ff == ST_WAIT);
  endproperty
  a_start: assert property (p_start)
    else $error("soft-start not begun with enables true");

  property p_wait_len;
    @(posedge aclk) disable iff (!aresetn) $rose(state_ff == ST_RAMP) |->
      ($past(state_ff) == ST_WAIT && $past(ss_cnt_ff) == 11'(SS_WAIT_CYCLES - 1));
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("ramp began before the start wait ended");

  property p_fast_step;
    @(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_RAMP && $past(state_ff) == ST_RAMP && $changed(dac_ff) &&
       int'($past(ss_cnt_ff)) < SS_FAST_CYCLES) |-> (dac_ff == $past(dac_ff) + 8'h2 || dac_ff == tgt);
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("early ramp step is not 25mV");

  property p_ofs_gone;
    @(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_RAMP && int'(ss_cnt_ff) >= SS_FAST_CYCLES) |-> (ofs_ff == 4'h0);
  endproperty
  a_ofs_gone: assert property (p_ofs_gone)
    else $error("sense offset not zero after fast ramp");

  property p_sample;
    @(posedge aclk) disable iff (!aresetn) !slot_pulse |=> $stable(vid_smp_ff);
  endproperty
  a_sample: assert property (p_sample)
    else $error("code sampled outside a slot");

  property p_run_step;
    @(posedge aclk) disable iff (!aresetn) (state_ff == ST_RUN && $past(state_ff) == ST_RUN) |->
      (dac_ff == $past(dac_ff) || dac_ff == $past(dac_ff) + 8'h1 || dac_ff == $past(dac_ff) - 8'h1);
  endproperty
  a_run_step: assert property (p_run_step)
    else $error("dac moved more than one step");

  property p_cancel;
    @(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_RUN && slot_pulse && cancel) |=> (!pend_ff && $stable(dac_ff));
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("reversed step not cancelled");

  property p_noload_delay;
    @(posedge aclk) disable iff (!aresetn)
      ($rose(ovsd_ff) && !$past(ov_latch_ff)) |-> ($past(nl_cnt_ff) == NOLOAD_DELAY_CYCLES);
  endproperty
  a_noload_delay: assert property (p_noload_delay)
    else $error("trip level changed before the no-load delay");

  property p_ov_hold;
    @(posedge aclk) disable iff (!aresetn)
      (ov_latch_ff && por_ok && en_cmp_high && logic_level_enable) |=> ov_latch_ff;
  endproperty
  a_ov_hold: assert property (p_ov_hold)
    else $error("overvoltage latch cleared without enable cycling");

  property p_pg;
    @(posedge aclk) disable iff (!aresetn) (state_ff != ST_RUN) |-> !pg_ff;
  endproperty
  a_pg: assert property (p_pg)
    else $error("power good high outside run");

  property p_pwm_wait;
    @(posedge aclk) disable iff (!aresetn) (state_ff == ST_RAMP && !reach_ff) |-> !pwm_ff;
  endproperty
  a_pwm_wait: assert property (p_pwm_wait)
    else $error("pwm enabled before dac reached output");
endmodule : vds_sequencer

// file: src/vds_pkg.sv
// package: constants, state type and decode helpers of the vid dac sequencer
// assumes: one aclk domain; every input is synchronous to aclk
package vds_pkg;
  localparam int SLOTS_PER_CYCLE = 6;
  localparam int HALF_CYCLE_SLOTS = SLOTS_PER_CYCLE / 2;
  localparam int SS_WAIT_CYCLES = 64;
  localparam int SS_FAST_CYCLES = 640;
  localparam int RAMP_CYC_PER_VOLT = 1280;
  localparam int UNITS_PER_VOLT = 80; // 1V over 12.5mV
  localparam int CYC_PER_UNIT = RAMP_CYC_PER_VOLT / UNITS_PER_VOLT;
  localparam int FAST_STEP_UNITS = 2; // 25mV
  localparam int FAST_STEP_CYCLES = CYC_PER_UNIT * FAST_STEP_UNITS;
  localparam logic [3:0] OFS_START_UNITS = 4'h8; // 100mV
  localparam int OFS_CYC_PER_UNIT = SS_FAST_CYCLES / int'(OFS_START_UNITS);
  localparam logic [1:0] NOLOAD_DELAY_CYCLES = 2'h2;
  localparam logic [5:0] VID_NOLOAD_A = 6'h3f;
  localparam logic [5:0] VID_NOLOAD_B = 6'h3e;
  localparam logic [5:0] VID_SPLIT = 6'h14;
  localparam logic [7:0] VID_LOW_BASE = 8'h57;
  localparam logic [7:0] VID_HIGH_BASE = 8'h95;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DAC = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_PG_BIT = 4;
  localparam int STAT_PWM_BIT = 5;
  localparam int STAT_OVL_BIT = 6;
  localparam int STAT_OVSD_BIT = 7;
  localparam int STAT_NOLOAD_BIT = 8;
  localparam int DAC_TGT_LSB = 8;
  localparam int DAC_OFS_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_SHUT = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_RAMP = 4'b0100,
    ST_RUN = 4'b1000
  } vds_state_t;

  // level in 12.5mV units for a six-bit code
  function automatic logic [7:0] vds_vid_units(input logic [5:0] code);
    if (code <= VID_SPLIT) begin
      return VID_LOW_BASE - {2'h0, code};
    end
    return VID_HIGH_BASE - {2'h0, code};
  endfunction : vds_vid_units

  function automatic logic vds_is_noload(input logic [5:0] code);
    return (code == VID_NOLOAD_A) || (code == VID_NOLOAD_B);
  endfunction : vds_is_noload
endpackage : vds_pkg

// file: src/vds_slot_timer.sv
// file: divider making sample-slot and switching-cycle enable pulses
// assumes: aclk free running; pulses last one aclk cycle
module vds_slot_timer #(
  parameter int SLOT_CLKS = 42
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic slot_pulse,
  output logic cycle_pulse
);
  import vds_pkg::*;
  localparam int CW = $clog2(SLOT_CLKS);

  if (SLOT_CLKS < 2) begin : g_bad_slot
    $error("SLOT_CLKS must be at least 2");
  end

  logic [CW-1:0] div_ff;
  logic [2:0] slot_ff;
  logic slot_pulse_ff;
  logic cycle_pulse_ff;
  logic div_end;

  assign div_end = (div_ff == CW'(SLOT_CLKS - 1));

  // aclk divider and slot index, six slots a switching cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      slot_ff <= 3'h0;
      slot_pulse_ff <= 1'b0;
      cycle_pulse_ff <= 1'b0;
    end else begin
      div_ff <= div_end ? '0 : div_ff + CW'(1);
      slot_pulse_ff <= div_end;
      cycle_pulse_ff <= div_end && (slot_ff == 3'(SLOTS_PER_CYCLE - 1));
      if (div_end) begin
        slot_ff <= (slot_ff == 3'(SLOTS_PER_CYCLE - 1)) ? 3'h0 : slot_ff + 3'h1;
      end
    end
  end

  assign slot_pulse = slot_pulse_ff;
  assign cycle_pulse = cycle_pulse_ff;
endmodule : vds_slot_timer

// file: src/vds_axil_slave.sv
// file: axi4-lite slave front end, one write and one read in flight
// assumes: master keeps valid and payload until ready; rd_data decodes rd_addr
module vds_axil_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import vds_pkg::*;

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff, rpend_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [ADDR_W-1:0] waddr_ff, raddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      waddr_ff <= '0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        waddr_ff <= s_axi_awaddr;
      end else if (bvalid_ff && s_axi_bready) begin
        awready_ff <= 1'b1;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (bvalid_ff && s_axi_bready) begin
        wready_ff <= 1'b1;
      end
    end
  end

  assign wr_en = !awready_ff && !wready_ff && !bvalid_ff;

  // write response follows the register update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // read: capture address, answer with decoded data next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rpend_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      raddr_ff <= '0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rpend_ff <= 1'b1;
      raddr_ff <= s_axi_araddr;
    end else if (rpend_ff) begin
      rpend_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_data;
      rresp_ff <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_addr = waddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign rd_addr = raddr_ff;
endmodule : vds_axil_slave

// file: bench/vds_proc_model.sv
// partner: processor driving the code, plus the output-level comparator
// assumes: shares aclk with the sequencer; the bench commands req and jump
module vds_proc_model #(
  parameter int STEP_CLKS = 48,
  parameter int VOUT_UNITS = 20
) (
  input wire logic aclk,
  input wire logic [5:0] req,
  input wire logic jump,
  input wire logic [7:0] dac_units,
  output logic [5:0] voltage_identification_code,
  output logic dac_reached_vout
);
  int cnt = 0;
  logic [5:0] code_ff = 6'h3f;
  // code follows req one step per interval, or at once when told to jump
  always @(posedge aclk) begin
    cnt <= (cnt + 1) % STEP_CLKS;
    if (jump) begin
      code_ff <= req;
    end else if (cnt == 0 && req > code_ff) begin
      code_ff <= code_ff + 6'h1;
    end else if (cnt == 0 && req < code_ff) begin
      code_ff <= code_ff - 6'h1;
    end
  end
  assign voltage_identification_code = code_ff;
  // pre-charged output sits at a fixed level
  assign dac_reached_vout = dac_units >= VOUT_UNITS;
endmodule : vds_proc_model

// file: bench/tb_top.sv
// bench: drives sequencer pins and register bus, checks the ports
// assumes: slot timer shortened to sc aclk per slot
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vds_pkg::*;
  localparam int SC = 4;
  localparam int CYC = 6 * SC;
  logic aclk = 0, aresetn = 0, jump = 1, ss_mon = 0, pwm, trip, pg, reached;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic por = 0, en_cmp = 0, llen = 0, win = 0, ov = 0;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] awaddr = 0, araddr = 0, dac, last = 0, exp_u;
  logic [31:0] wdata = 0, rdata, rd;
  logic [5:0] req = 6'h3f, code;
  logic [3:0] ofs;
  logic [16:0] rnd = 17'h1792e;
  int num_errors = 0, check_count = 0, n;
  always #4 aclk = ~aclk;
  vds_sequencer #(.SLOT_CLKS(SC)) vds_sequencer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .por_ok(por), .en_cmp_high(en_cmp), .logic_level_enable(llen),
    .voltage_identification_code(code), .dac_reached_vout(reached),
    .vout_in_window(win), .ov_detect(ov), .dac_units(dac), .rs_offset_units(ofs),
    .pwm_drive_en(pwm), .ov_trip_shutdown(trip), .power_good_output(pg));
  vds_proc_model vds_proc_model_i (.aclk(aclk), .req(req), .jump(jump), .dac_units(dac),
    .voltage_identification_code(code), .dac_reached_vout(reached));
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr
  // level of a code in 12.5mV units
  function automatic logic [7:0] units(input logic [5:0] c);
    return (c <= 6'h14) ? 8'h57 - c : 8'h95 - c;
  endfunction : units
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // bus write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      awvalid <= !ta;
      wvalid <= !tw;
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 0;
  endtask : axr
  task automatic wait_dac(input logic [7:0] v);
    for (int i = 0; i < 40000 && dac !== v; i++) @(posedge aclk);
  endtask : wait_dac
  // soft-start step sizes and pwm hold-off
  always @(posedge aclk) begin
    if (ss_mon && dac != last) chk(dac - last, (last < 8'h28) ? 2 : 1);
    if (ss_mon && dac < 8'h14) chk(pwm, 0);
    last <= dac;
  end
  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    cyc(2);
    aresetn <= 1;
    chk({pwm, pg, dac}, 0);
    axr(REG_STATUS);
    chk(rd, 32'h101);
    axr(8'h0c);
    chk(resp, RESP_SLVERR);
    chk(rd, 0);
    axw(8'h0c, 1);
    chk(resp, RESP_SLVERR);
    axw(REG_CTRL, 0);
    por <= 1;
    en_cmp <= 1;
    llen <= 1;
    req <= 6'h14;
    cyc(40);
    axr(REG_STATUS);
    chk(rd[3:0], 1);
    axw(REG_CTRL, 1);
    ss_mon <= 1;
    cyc(8);
    chk({ofs, dac}, {4'h8, 8'h0});
    for (n = 8; n < 200 * CYC && dac === 8'h0; n++) @(posedge aclk);
    chk(n >= 93 * CYC && n <= 97 * CYC, 1);
    wait_dac(8'h2a);
    chk(ofs, 0);
    wait_dac(units(6'h14));
    chk(dac, 8'h43);
    ss_mon <= 0;
    win <= 1;
    cyc(4);
    chk({pwm, pg}, 2'b11);
    req <= 6'h13;
    cyc(SC);
    req <= 6'h14;
    cyc(4 * CYC);
    chk(dac, 8'h43);
    req <= 6'h13;
    cyc(2 * SC);
    chk(dac, 8'h43);
    cyc(CYC);
    chk(dac, 8'h44);
    rnd = lfsr(rnd);
    exp_u = units({2'h0, rnd[3:0]});
    req <= {2'h0, rnd[3:0]};
    cyc(2 * SC + 1);
    chk(dac < exp_u, 1);
    cyc(20 * SC + CYC);
    chk(dac, exp_u);
    axr(REG_DAC);
    chk(rd, {12'h0, 4'h0, exp_u, exp_u});
    jump <= 0;
    req <= 6'h14;
    wait_dac(8'h43);
    chk(dac, 8'h43);
    jump <= 1;
    req <= 6'h3f;
    cyc(16);
    chk(pwm, 1);
    cyc(80);
    chk({pwm, trip, pg}, 3'b010);
    req <= 6'h14;
    cyc(16);
    axr(REG_STATUS);
    chk(rd[3:0], 2);
    ov <= 1;
    cyc(1);
    ov <= 0;
    cyc(4);
    axr(REG_STATUS);
    chk({rd[6], rd[3:0]}, 5'h11);
    req <= 6'h3f;
    cyc(3 * CYC);
    req <= 6'h14;
    cyc(3 * CYC);
    axr(REG_STATUS);
    chk(rd[3:0], 1);
    llen <= 0;
    cyc(2);
    llen <= 1;
    cyc(16);
    axr(REG_STATUS);
    chk(rd[3:0], 2);
    give_verdict();
  end
endmodule : tb_top
